// >>> dtm_temp_sensor.sv
// Die temperature sensor control, result registers and interrupt request.
`timescale 1ns/1ps
`include "dtm_defs.svh"
module dtm_temp_sensor #(
  parameter int unsigned SENSOR_DIV = `DTM_SENSOR_DIV
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire dtm_pkg::dtm_sfr_req_t i_sfr,
  input wire dtm_pkg::dtm_temp_word_t i_sensor_temp,
  input wire logic i_temp_irq_enable,
  output logic [7:0] o_sfr_rdata,
  output logic o_temp_irq,
  output logic o_busy
);
  import dtm_pkg::*;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic ctrl_hit;
  logic low_hit;
  logic high_hit;
  logic ctrl_wr;
  logic start_pulse;
  logic conv_busy;
  logic conv_done;

  // The control and low result bytes share one address; only the page tells them apart.
  assign ctrl_hit = (i_sfr.page == `DTM_PAGE_CTRL) && (i_sfr.addr == `DTM_ADDR_CTRL); // [RULE_09]
  assign low_hit = (i_sfr.page == `DTM_PAGE_DATA) && (i_sfr.addr == `DTM_ADDR_LOW); // [RULE_08]
  assign high_hit = (i_sfr.page == `DTM_PAGE_DATA) && (i_sfr.addr == `DTM_ADDR_HIGH); // [RULE_07]
  assign ctrl_wr = i_sfr.wr && ctrl_hit;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic start_ff;
  logic fin_ff;
  logic nxt_fin;
  logic [2:0] len_ff;
  dtm_temp_word_t result_ff;

  // A measurement begins on the write that returns the start bit to zero.
  assign start_pulse = ctrl_wr && start_ff && !i_sfr.wdata[`DTM_START_BIT]; // [RULE_01]

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_ff <= 1'b0; // [RULE_13]
      len_ff <= `DTM_LEN_RESET;
    end else if (ctrl_wr) begin
      start_ff <= i_sfr.wdata[`DTM_START_BIT]; // [RULE_01]
      len_ff <= i_sfr.wdata[`DTM_LEN_MSB:`DTM_LEN_LSB]; // [RULE_05]
    end
  end

  // Completion wins over a firmware clear in the same cycle, so no completion is lost.
  always_comb begin
    nxt_fin = fin_ff;
    if (ctrl_wr && !i_sfr.wdata[`DTM_DONE_BIT]) begin
      nxt_fin = 1'b0; // [RULE_04]
    end
    if (conv_done) begin
      nxt_fin = 1'b1; // [RULE_02]
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fin_ff <= 1'b0; // [RULE_13]
    end else begin
      fin_ff <= nxt_fin; // [RULE_02]
    end
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  // The word is sign, eight integer and seven fraction bits, stored as delivered.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      result_ff <= '0; // [RULE_13]
    end else if (conv_done) begin
      result_ff <= i_sensor_temp; // [RULE_06] [RULE_10] [RULE_12]
    end else begin
      if (i_sfr.wr && low_hit) begin
        result_ff.low <= i_sfr.wdata; // [RULE_08]
      end
      if (i_sfr.wr && high_hit) begin
        result_ff.high <= i_sfr.wdata; // [RULE_07]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Conversion timer
  // ----------------------------------------------------------------------
  dtm_conv_timer #(
    .SENSOR_DIV(SENSOR_DIV)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_start(start_pulse),
    .i_len_sel(len_ff),
    .o_busy(conv_busy),
    .o_done(conv_done)
  );

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= conv_busy;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------------
  // The request follows the flag as a level, so firmware drops it by clearing the flag.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_temp_irq <= 1'b0;
    end else begin
      o_temp_irq <= nxt_fin && i_temp_irq_enable; // [RULE_03] [RULE_11]
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Reserved bits and unmapped addresses read as zero.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sfr_rdata <= `DTM_BYTE_RESET;
    end else if (i_sfr.rd) begin
      if (ctrl_hit) begin
        o_sfr_rdata <= {start_ff, fin_ff, 3'h0, len_ff}; // [RULE_09]
      end else if (low_hit) begin
        o_sfr_rdata <= result_ff.low; // [RULE_08]
      end else if (high_hit) begin
        o_sfr_rdata <= result_ff.high; // [RULE_07]
      end else begin
        o_sfr_rdata <= `DTM_BYTE_RESET;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_start_on_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_01]
    start_pulse && !conv_busy |=> conv_busy ##1 o_busy)
    else $error("Start sequence did not begin a measurement.");

  a_no_start_high: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_13]
    !conv_busy && !start_pulse |=> !conv_busy)
    else $error("Measurement began without the start sequence.");

  a_done_sets_flag: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_02]
    conv_done |=> fin_ff)
    else $error("Completion did not set the finished flag.");

  a_flag_sticky: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_02]
    fin_ff && !(ctrl_wr && !i_sfr.wdata[`DTM_DONE_BIT]) |=> fin_ff)
    else $error("Finished flag dropped without a firmware clear.");

  a_irq_on_flag: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_03]
    conv_done && i_temp_irq_enable |=> o_temp_irq && fin_ff)
    else $error("Enabled completion raised no interrupt.");

  a_irq_masked: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_11]
    !i_temp_irq_enable |=> !o_temp_irq)
    else $error("Interrupt raised while disabled.");

  a_result_loaded: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_12]
    conv_done |=> fin_ff && result_ff == $past(i_sensor_temp))
    else $error("Result not loaded with the finished flag.");

  a_read_ctrl: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_09]
    i_sfr.rd && ctrl_hit |=> o_sfr_rdata == {$past(start_ff), $past(fin_ff), 3'h0, $past(len_ff)})
    else $error("Control read returned the wrong byte.");

  a_read_high: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_07]
    i_sfr.rd && high_hit |=> o_sfr_rdata == $past(result_ff.high))
    else $error("High result read returned the wrong byte.");

  a_read_low: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_08]
    i_sfr.rd && low_hit |=> o_sfr_rdata == $past(result_ff.low))
    else $error("Low result read returned the wrong byte.");

  a_read_unmapped: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_09]
    i_sfr.rd && !ctrl_hit && !low_hit && !high_hit |=> o_sfr_rdata == `DTM_BYTE_RESET)
    else $error("Unmapped read returned a nonzero byte.");

  a_result_stable: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_06]
    !conv_done && !(i_sfr.wr && (low_hit || high_hit)) |=> $stable(result_ff))
    else $error("Result changed without a completion or a write.");

  a_write_low: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_08]
    i_sfr.wr && low_hit && !conv_done |=> result_ff.low == $past(i_sfr.wdata))
    else $error("Low result write did not land.");

  a_write_high: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_07]
    i_sfr.wr && high_hit && !conv_done |=> result_ff.high == $past(i_sfr.wdata))
    else $error("High result write did not land.");

  a_ctrl_keeps_result: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_09]
    ctrl_wr && !conv_done |=> result_ff == $past(result_ff))
    else $error("Control write disturbed the result bytes.");

  a_flag_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_04]
    fin_ff && ctrl_wr && !i_sfr.wdata[`DTM_DONE_BIT] && !conv_done |=> !fin_ff)
    else $error("Firmware clear did not drop the finished flag.");

  a_flag_no_soft: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_02]
    !fin_ff && !conv_done |=> !fin_ff)
    else $error("Finished flag set without a completion.");

  a_len_written: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_05]
    ctrl_wr |=> len_ff == $past(i_sfr.wdata[`DTM_LEN_MSB:`DTM_LEN_LSB]))
    else $error("Length field write did not land.");

  a_irq_drops: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_03]
    !fin_ff |-> !o_temp_irq)
    else $error("Interrupt raised while the finished flag is clear.");

endmodule

// >>> dtm_defs.svh
// Register map, field positions and timing constants of the die temperature block.
//
// Functional notes
// RULE_01: Start measurement when start bit returns to zero.
// RULE_02: Hardware sets finished flag on completion.
// RULE_03: Enabled interrupt raised when finished flag sets.
// RULE_04: Firmware clears finished flag before next completion.
// RULE_05: Length field sets measurement duration by formula.
// RULE_06: Result is 16-bit two's complement value.
// RULE_07: High result byte at 0xD3, page 0.
// RULE_08: Low result byte at 0xD2, page 0.
// RULE_09: Control at 0xD2 page F, page distinguishes.
// RULE_10: Result is sign, 8 integer, 7 fraction bits.
// RULE_11: Separate external enable gates the interrupt.
// RULE_12: Result loaded no later than finished flag.
// RULE_13: Reset clears everything; no measurement until start.
`ifndef DTM_DEFS_SVH
`define DTM_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DTM_ADDR_CTRL 8'hd2
`define DTM_ADDR_LOW 8'hd2
`define DTM_ADDR_HIGH 8'hd3
`define DTM_PAGE_CTRL 4'hf
`define DTM_PAGE_DATA 4'h0
`define DTM_BYTE_RESET 8'h00

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DTM_START_BIT 7
`define DTM_DONE_BIT 6
`define DTM_LEN_MSB 2
`define DTM_LEN_LSB 0
`define DTM_LEN_RESET 3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DTM_MCLK_MHZ 125
`define DTM_SETTLE_US 32
`define DTM_SETTLE_CYC (`DTM_SETTLE_US * `DTM_MCLK_MHZ)
`define DTM_TICKS_PER_UNIT 256
`define DTM_SENSOR_DIV 50

`endif

// >>> dtm_pkg.sv
// Types shared by the die temperature block.
package dtm_pkg;

  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dtm_sfr_req_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dtm_temp_word_t;

  typedef enum logic [1:0] {
    DTM_IDLE,
    DTM_SENSE,
    DTM_SETTLE
  } dtm_tmr_state_t;

endpackage

// >>> dtm_conv_timer.sv
// Conversion length timer driven by the sensor clock enable.
`timescale 1ns/1ps
`include "dtm_defs.svh"
module dtm_conv_timer #(
  parameter int unsigned SENSOR_DIV = `DTM_SENSOR_DIV
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [2:0] i_len_sel,
  output logic o_busy,
  output logic o_done
);
  import dtm_pkg::*;

  dtm_tmr_state_t state_ff;
  logic [2:0] len_ff;
  logic [15:0] div_ff;
  logic [7:0] tick_ff;
  logic [8:0] unit_ff;
  logic [11:0] settle_ff;
  logic sense_tick;
  logic sense_last;
  logic settle_last;
  logic [8:0] unit_total;
  logic [31:0] cyc_ff;

  // Units of 256 sensor ticks: two to the power of length plus one, plus one.
  assign unit_total = 9'((9'h1 << ({1'b0, i_len_sel} + 4'h1)) + 9'h1); // [RULE_05]
  assign sense_tick = (div_ff == 16'(SENSOR_DIV - 1));
  assign sense_last = sense_tick && (tick_ff == 8'(`DTM_TICKS_PER_UNIT - 1)) && (unit_ff == 9'h0);
  assign settle_last = (settle_ff == 12'(`DTM_SETTLE_CYC - 1));
  assign o_busy = (state_ff != DTM_IDLE);

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= DTM_IDLE;
      len_ff <= `DTM_LEN_RESET;
      div_ff <= '0;
      tick_ff <= '0;
      unit_ff <= '0;
      settle_ff <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_ff)
        DTM_IDLE: begin
          if (i_start) begin
            state_ff <= DTM_SENSE;
            len_ff <= i_len_sel;
            div_ff <= '0;
            tick_ff <= '0;
            unit_ff <= unit_total - 9'h1; // [RULE_05]
          end
        end
        DTM_SENSE: begin
          div_ff <= sense_tick ? 16'h0 : div_ff + 16'h1;
          if (sense_tick) begin
            tick_ff <= tick_ff + 8'h1;
            if (tick_ff == 8'(`DTM_TICKS_PER_UNIT - 1)) begin
              unit_ff <= unit_ff - 9'h1;
            end
          end
          if (sense_last) begin
            state_ff <= DTM_SETTLE;
            settle_ff <= '0;
          end
        end
        DTM_SETTLE: begin
          settle_ff <= settle_ff + 12'h1;
          if (settle_last) begin
            state_ff <= DTM_IDLE;
            o_done <= 1'b1;
          end
        end
        default: begin
          state_ff <= DTM_IDLE;
        end
      endcase
    end
  end

  // Cycles since the accepted start, read only by the length check.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cyc_ff <= '0;
    end else begin
      cyc_ff <= (i_start && !o_busy) ? 32'h1 : cyc_ff + 32'h1;
    end
  end

  a_conv_length: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // [RULE_05]
    o_done |-> cyc_ff == 32'(((32'h1 << (len_ff + 32'h1)) + 32'h1) * `DTM_TICKS_PER_UNIT * SENSOR_DIV
      + `DTM_SETTLE_CYC + 1))
    else $error("Conversion length does not match the length field.");

endmodule

// >>> dtm_temp_sensor_tb.sv
// Self-checking testbench of the die temperature measurement block.
`timescale 1ns/1ps
`include "dtm_defs.svh"
module dtm_temp_sensor_tb;
  import dtm_pkg::*;
  // --------------------------------------------------------------------
  // Stimulus and bookkeeping
  // --------------------------------------------------------------------
  // A sensor divider of one keeps conversion lengths 0 to 3 short enough to run.
  localparam int unsigned DIV = 1;
  localparam int LIMIT = 30000;
  logic i_mclk;
  logic i_sys_rst = 1'b1;
  dtm_sfr_req_t sfr = '0;
  dtm_temp_word_t temp = '0;
  logic irq_en = 1'b0;
  logic [7:0] o_sfr_rdata;
  logic o_temp_irq;
  logic o_busy;
  logic [31:0] rng = 32'h32;
  logic [7:0] rd;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;

  dtm_temp_sensor #(.SENSOR_DIV(DIV)) u_dut (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_sfr(sfr),
    .i_sensor_temp(temp),
    .i_temp_irq_enable(irq_en),
    .o_sfr_rdata(o_sfr_rdata),
    .o_temp_irq(o_temp_irq),
    .o_busy(o_busy)
  );

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures = failures + 1;
      $display("BAD timeout expected %0d seen %0d", LIMIT, cyc);
      conclude();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkn(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // One access, entered and left on a rising edge; read data lands in rd.
  task automatic acc(input logic [3:0] pg, input logic [7:0] ad, input logic w, input logic [7:0] d);
    sfr <= '{page: pg, addr: ad, wr: w, rd: ~w, wdata: d};
    @(posedge i_mclk);
    sfr <= '0;
    @(negedge i_mclk);
    rd = o_sfr_rdata;
    @(posedge i_mclk);
  endtask

  // --------------------------------------------------------------------
  // One measurement, with a start attempt while busy that must be ignored
  // --------------------------------------------------------------------
  task automatic measure(input logic [2:0] len, input logic en);
    logic [15:0] w;
    int n;
    n = ((2 ** (len + 4'h1)) + 1) * `DTM_TICKS_PER_UNIT * DIV + `DTM_SETTLE_CYC + 1;
    rng = xs(rng);
    w = (len == 3'h0) ? 16'h8000 : rng[15:0];
    temp <= w;
    irq_en <= en;
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, {5'h10, len});
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, {5'h00, len});
    #1;
    t0 = cyc - 1;
    @(posedge i_mclk);
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, {5'h10, len});
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, {5'h00, len});
    #1;
    if (en) begin
      while (o_temp_irq !== 1'b1 && cyc < LIMIT) @(negedge i_mclk);
      chkn("irq delay", n, cyc - t0);
    end else begin
      while (o_busy !== 1'b0 && cyc < LIMIT) @(negedge i_mclk);
      chkn("busy length", n, cyc - t0);
      chk8("masked irq", 8'h00, {7'h0, o_temp_irq});
    end
    @(posedge i_mclk);
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, {5'h08, len});
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b0, 8'h00);
    chk8("control done", {5'h08, len}, rd);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_LOW, 1'b0, 8'h00);
    chk8("result low", w[7:0], rd);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_HIGH, 1'b0, 8'h00);
    chk8("result high", w[15:8], rd);
    irq_en <= 1'b1;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk8("enabled irq", 8'h01, {7'h0, o_temp_irq});
    @(posedge i_mclk);
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, {5'h00, len});
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b0, 8'h00);
    chk8("control cleared", {5'h00, len}, rd);
    chk8("irq cleared", 8'h00, {7'h0, o_temp_irq});
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    logic [3:0] pg [5];
    logic [7:0] ad [5];
    pg = '{4'hf, 4'h0, 4'h0, 4'h0, 4'hf};
    ad = '{8'hd2, 8'hd2, 8'hd3, 8'hd4, 8'hd3};
    repeat (5) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    for (int i = 0; i < 5; i++) begin
      acc(pg[i], ad[i], 1'b0, 8'h00);
      chk8("reset or unmapped read", 8'h00, rd);
    end
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, 8'h3d);
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b0, 8'h00);
    chk8("reserved bits", 8'h05, rd);
    chk8("idle busy", 8'h00, {7'h0, o_busy});
    rng = xs(rng);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_LOW, 1'b1, rng[7:0]);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_HIGH, 1'b1, rng[15:8]);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_LOW, 1'b0, 8'h00);
    chk8("low write", rng[7:0], rd);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_HIGH, 1'b0, 8'h00);
    chk8("high write", rng[15:8], rd);
    for (int l = 0; l < 4; l++) measure(l[2:0], ~l[0]);
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, 8'h87);
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b1, 8'h07);
    repeat (10) @(posedge i_mclk);
    @(negedge i_mclk);
    chk8("busy running", 8'h01, {7'h0, o_busy});
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    @(negedge i_mclk);
    chk8("busy in reset", 8'h00, {7'h0, o_busy});
    @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    acc(`DTM_PAGE_CTRL, `DTM_ADDR_CTRL, 1'b0, 8'h00);
    chk8("control after reset", 8'h00, rd);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_LOW, 1'b0, 8'h00);
    chk8("low after reset", 8'h00, rd);
    acc(`DTM_PAGE_DATA, `DTM_ADDR_HIGH, 1'b0, 8'h00);
    chk8("high after reset", 8'h00, rd);
    conclude();
  end
endmodule
